// File: common/sfs_pkg.sv
// sfs_pkg: constants and types shared by the serial flash front end.
// assumes the core runs on a 25 MHz system clock far faster than the shift clock.
package sfs_pkg;

    localparam int unsigned CLK_SYS_MHZ  = 25;
    localparam int unsigned BYTE_BITS    = 8;
    localparam logic [2:0]  BIT_CNT_LAST = 3'h7;
    localparam logic [2:0]  BIT_CNT_ZERO = 3'h0;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [2:0]  SYNC_ZERO    = 3'h0;
    localparam logic [2:0]  SYNC_ONES    = 3'h7;
    localparam int unsigned SYNC_MID     = 1;
    localparam int unsigned SYNC_OLD     = 2;

    // front end states, one-hot
    typedef enum logic [3:0] {
        SFS_IDLE = 4'h1,
        SFS_SHIFT = 4'h2,
        SFS_BUSY = 4'h4,
        SFS_DONE = 4'h8
    } sfs_state_t;

endpackage

// File: rtl/sfs_sync.sv
// sfs_sync: three-stage synchroniser with agreement of the last two stages.
// assumes the input is asynchronous to clk_sys_i.
`timescale 1ns/1ns
module sfs_sync (
    input  wire logic clk_sys_i,  // system clock
    input  wire logic rst_n_i,    // async reset, active low
    input  wire logic rst_val_i,  // level to settle on after reset
    input  wire logic async_i,    // raw pin
    output logic      level_o     // filtered level
);
    import sfs_pkg::*;

    typedef struct packed {
        logic [2:0] pipe;
        logic       level;
        logic       seeded;
    } sfs_sync_t;

    sfs_sync_t cur;
    sfs_sync_t next_cur;

    // stage 0 only feeds stage 1; level moves once stages 1 and 2 agree
    always_comb begin
        next_cur = cur;
        next_cur.pipe = {cur.pipe[1:0], async_i};
        if (!cur.seeded) begin
            next_cur.seeded = 1'b1;
            next_cur.level = rst_val_i;
            next_cur.pipe = rst_val_i ? SYNC_ONES : SYNC_ZERO;  // stages agree with seed
        end else if (cur.pipe[SYNC_MID] == cur.pipe[SYNC_OLD]) begin
            next_cur.level = cur.pipe[SYNC_OLD];
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign level_o = cur.level;
endmodule

// File: rtl/sfs_frontend.sv
// sfs_frontend: serial interface front end of a serial flash memory.
// assumes a host spi master drives select, shift clock and input; core behind
// consumes bytes, supplies read bytes and reports its internal busy cycle.
//
// What this block does
// - a falling select edge alone starts a new command sequence, except in the busy state
// - a rising select edge ends the current command sequence
// - after select rises, standby waits until the internal timed cycle completes
// - serial input is sampled on every rising shift clock edge
// - serial output changes only after falling shift clock edges
// - command, address and data all arrive as one serial input stream
// - shift clock may idle low or high; same edges in both modes
`timescale 1ns/1ns
module sfs_frontend (
    input  wire logic              clk_sys_i,    // system clock 25 MHz
    input  wire logic              rst_n_i,      // async reset, active low
    input  wire logic              sel_n_i,      // chip select pin, active low
    input  wire logic              sck_i,        // shift clock pin
    input  wire logic              sdi_i,        // serial input pin
    output logic                   sdo_o,        // serial output level
    output logic                   sdo_oe_o,     // serial output enable
    output logic                   start_o,      // pulse: sequence begins
    output logic                   end_o,        // pulse: sequence ends
    output logic [7:0]             rx_byte_o,    // last received byte
    output logic                   rx_valid_o,   // pulse: rx_byte_o new
    output logic                   rx_first_o,   // rx byte is the first of sequence
    input  wire logic [7:0]        tx_byte_i,    // byte to shift out next
    input  wire logic              tx_en_i,      // core requests output phase
    output logic                   tx_load_o,    // pulse: tx_byte_i taken
    input  wire logic              core_busy_i,  // internal program/erase running
    output logic                   active_o,     // device not in standby
    output sfs_pkg::sfs_state_t    state_o       // front end state
);
    import sfs_pkg::*;

    ////////////////////////////////////////////////////////////////
    // pin synchronisers; select passes inverted so cleared stages read as
    // deselected and no false select edge follows reset
    logic sel_act_s;
    logic sel_n_s;
    logic sck_s;
    logic sdi_s;

    sfs_sync u_sync_sel (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .rst_val_i (1'b0),
        .async_i   (~sel_n_i),
        .level_o   (sel_act_s)
    );

    assign sel_n_s = ~sel_act_s;

    // seeding the clock with its own pin level sets sck_s one cycle after reset; in mode 3 that rise still meets sck_d reset low, while idle
    sfs_sync u_sync_sck (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .rst_val_i (sck_i),
        .async_i   (sck_i),
        .level_o   (sck_s)
    );

    sfs_sync u_sync_sdi (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .rst_val_i (1'b0),
        .async_i   (sdi_i),
        .level_o   (sdi_s)
    );

    ////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        sfs_state_t state;
        logic       sel_d;
        logic       sck_d;
        logic [2:0] rx_cnt;
        logic [7:0] rx_sh;
        logic [7:0] rx_byte;
        logic       rx_valid;
        logic       rx_first;
        logic       first_pend;
        logic [2:0] tx_cnt;
        logic [7:0] tx_sh;
        logic       tx_live;
        logic       sdo;
        logic       oe;
        logic       start;
        logic       fin;
        logic       tx_load;
    } sfs_core_t;

    sfs_core_t cur;
    sfs_core_t next_cur;

    logic sel_fall;
    logic sel_rise;
    logic sck_rise;
    logic sck_fall;

    // edge detection on filtered levels
    assign sel_fall = cur.sel_d & ~sel_n_s;
    assign sel_rise = ~cur.sel_d & sel_n_s;
    assign sck_rise = ~cur.sck_d & sck_s;
    assign sck_fall = cur.sck_d & ~sck_s;

    ////////////////////////////////////////////////////////////////
    // next state logic
    always_comb begin
        next_cur = cur;
        next_cur.sel_d = sel_n_s;
        next_cur.sck_d = sck_s;
        next_cur.start = 1'b0;
        next_cur.fin = 1'b0;
        next_cur.rx_valid = 1'b0;
        next_cur.tx_load = 1'b0;
        unique case (cur.state)
            SFS_IDLE, SFS_DONE: begin
                // only the select falling edge opens a sequence
                if (sel_fall) begin
                    next_cur.state = SFS_SHIFT;
                    next_cur.start = 1'b1;
                    next_cur.rx_cnt = BIT_CNT_ZERO;
                    next_cur.tx_cnt = BIT_CNT_ZERO;
                    next_cur.tx_live = 1'b0;
                    next_cur.first_pend = 1'b1;
                    next_cur.oe = 1'b0;
                end else if (cur.state == SFS_DONE) begin
                    next_cur.state = SFS_IDLE;
                end
            end
            SFS_SHIFT: begin
                if (sel_rise) begin
                    next_cur.fin = 1'b1;
                    next_cur.oe = 1'b0;
                    next_cur.tx_live = 1'b0;
                    next_cur.state = core_busy_i ? SFS_BUSY : SFS_DONE;
                end else begin
                    // one input stream for command, address and data
                    if (sck_rise) begin
                        next_cur.rx_sh = {cur.rx_sh[6:0], sdi_s};
                        next_cur.rx_cnt = cur.rx_cnt + 3'h1;
                        if (cur.rx_cnt == BIT_CNT_LAST) begin
                            next_cur.rx_byte = {cur.rx_sh[6:0], sdi_s};
                            next_cur.rx_valid = 1'b1;
                            next_cur.rx_first = cur.first_pend;
                            next_cur.first_pend = 1'b0;
                        end
                    end
                    // output moves only after a falling clock edge
                    if (sck_fall) begin
                        if (!tx_en_i) begin
                            next_cur.oe = 1'b0;
                            next_cur.tx_live = 1'b0;
                            next_cur.tx_cnt = BIT_CNT_ZERO;
                        end else if (!cur.tx_live || cur.tx_cnt == BIT_CNT_LAST) begin
                            next_cur.tx_sh = {tx_byte_i[6:0], 1'b0};
                            next_cur.sdo = tx_byte_i[BYTE_BITS-1];
                            next_cur.tx_load = 1'b1;
                            next_cur.tx_live = 1'b1;
                            next_cur.tx_cnt = BIT_CNT_ZERO;
                            next_cur.oe = 1'b1;
                        end else begin
                            next_cur.sdo = cur.tx_sh[BYTE_BITS-1];
                            next_cur.tx_sh = {cur.tx_sh[6:0], 1'b0};
                            next_cur.tx_cnt = cur.tx_cnt + 3'h1;
                        end
                    end
                end
            end
            SFS_BUSY: begin
                // stay active until the internal timed cycle finishes
                next_cur.oe = 1'b0;
                if (!core_busy_i) begin
                    next_cur.state = SFS_DONE;
                end
            end
        endcase
        // select high always releases the output
        if (sel_n_s) begin
            next_cur.oe = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur <= '{state: SFS_IDLE, sel_d: 1'b1, sck_d: 1'b0,
                     rx_cnt: BIT_CNT_ZERO, rx_sh: BYTE_ZERO, rx_byte: BYTE_ZERO,
                     rx_valid: 1'b0, rx_first: 1'b0, first_pend: 1'b0,
                     tx_cnt: BIT_CNT_ZERO, tx_sh: BYTE_ZERO, tx_live: 1'b0,
                     sdo: 1'b0, oe: 1'b0, start: 1'b0, fin: 1'b0, tx_load: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign sdo_o = cur.sdo;
    assign sdo_oe_o = cur.oe;
    assign start_o = cur.start;
    assign end_o = cur.fin;
    assign rx_byte_o = cur.rx_byte;
    assign rx_valid_o = cur.rx_valid;
    assign rx_first_o = cur.rx_first;
    assign tx_load_o = cur.tx_load;
    assign active_o = (cur.state != SFS_IDLE);
    assign state_o = cur.state;
endmodule

// File: verif/sfs_frontend_sva.sv
// sfs_frontend_sva: port timing assertions on the front end.
// assumes binding onto sfs_frontend; reset asynchronous, active low.
`timescale 1ns/1ns
module sfs_frontend_sva import sfs_pkg::*; (
    input  wire logic          clk_sys_i,   // clock
    input  wire logic          rst_n_i,     // reset
    input  wire logic          sel_n_i,     // select pin
    input  wire logic          sck_i,       // shift clock
    input  wire logic          core_busy_i, // core busy
    input  wire logic          sdo_o,       // data out
    input  wire logic          sdo_oe_o,    // out enable
    input  wire logic          start_o,     // start pulse
    input  wire logic          end_o,       // end pulse
    input  wire logic          rx_valid_o,  // byte pulse
    input  wire logic          tx_load_o,   // load pulse
    input  wire logic          active_o,    // not standby
    input  sfs_pkg::sfs_state_t state_o     // state
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    property p_start_fall; (state_o == SFS_IDLE && $fell(sel_n_i)) |-> ##[2:7] start_o; endproperty
    a_start_fall: assert property (p_start_fall) else $error("no start after select fall");
    property p_start_shift; start_o |-> ##[0:1] (state_o == SFS_SHIFT); endproperty
    a_start_shift: assert property (p_start_shift) else $error("start without shift");
    property p_end_rise; ($rose(sel_n_i) && state_o == SFS_SHIFT) |-> ##[2:7] end_o; endproperty
    a_end_rise: assert property (p_end_rise) else $error("no end after select rise");
    property p_busy_hold; (state_o == SFS_BUSY && core_busy_i) |=> (state_o == SFS_BUSY && active_o);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("left busy too early");
    property p_rx_shift; rx_valid_o |-> state_o == SFS_SHIFT; endproperty
    a_rx_shift: assert property (p_rx_shift) else $error("byte outside sequence");
    property p_sdo_fall; ($changed(sdo_o) && sdo_oe_o) |-> (!$past(sck_i, 4) || !$past(sck_i, 5));
    endproperty
    a_sdo_fall: assert property (p_sdo_fall) else $error("output moved without fall");
    property p_oe_desel; sel_n_i [*8] |-> !sdo_oe_o; endproperty
    a_oe_desel: assert property (p_oe_desel) else $error("output driven deselected");
    property p_idle_quiet; state_o == SFS_IDLE |-> (!sdo_oe_o && !active_o); endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle but driving");
    property p_load_oe; tx_load_o |-> ##[0:1] sdo_oe_o; endproperty
    a_load_oe: assert property (p_load_oe) else $error("load without enable");
    c_busy: cover property (state_o == SFS_BUSY);
    c_load: cover property (tx_load_o);
    c_end: cover property (end_o);
endmodule
bind sfs_frontend sfs_frontend_sva u_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .sel_n_i(sel_n_i), .sck_i(sck_i), .core_busy_i(core_busy_i), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .start_o(start_o), .end_o(end_o), .rx_valid_o(rx_valid_o),
    .tx_load_o(tx_load_o), .active_o(active_o), .state_o(state_o));

// File: verif/sfs_host_model.sv
// sfs_host_model: behavioural host spi master for select, clock and input.
// assumes device output is trusted only while its enable is high.
`timescale 1ns/1ns
module sfs_host_model (
    output logic      sel_n_o,  // select, active low
    output logic      sck_o,    // shift clock
    output logic      sdi_o,    // data to device
    input  wire logic sdo_i,    // data from device
    input  wire logic sdo_oe_i  // device drives data
);
    bit mode3;
    // idle levels at time zero
    initial begin
        sel_n_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
    end
    // clock parked at mode level, then select falls
    task automatic open_seq();
        sck_o = mode3;
        #200;
        sel_n_o = 1'b0;
        #160;
    endtask
    // n bits msb first, input set at fall, output read late
    task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck_o = 1'b0;
            sdi_o = d[i];
            #160;
            sck_o = 1'b1;
            #155;
            r[i] = sdo_oe_i ? sdo_i : ~sdo_i;
            #5;
        end
    endtask
    // clock back to idle, select rises, released input toggles
    task automatic close_seq();
        sck_o = mode3;
        #160;
        sel_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #400;
    endtask
endmodule

// File: verif/serial_flash_spi_frontend_test.sv
// serial_flash_spi_frontend_test: random and corner sequences through the front end.
// assumes sfs_host_model plays the host; bench plays the core.
`timescale 1ns/1ns
module serial_flash_spi_frontend_test;
    import sfs_pkg::*;
    logic clk_sys_i = 0, rst_n_i = 0, tx_en_i = 0, core_busy_i = 0;
    logic sel_n_i, sck_i, sdi_i, sdo_o, sdo_oe_o, start_o, end_o;
    logic rx_valid_o, rx_first_o, tx_load_o, active_o;
    logic [7:0] rx_byte_o, tx_byte_i = 8'h00;
    sfs_state_t state_o;
    int num_errors = 0, total_checks = 0, seed = 31, cyc = 0, n_start = 0, n_end = 0;
    logic [8:0] rxq[$];
    logic [7:0] txq[$];
    initial forever #20 clk_sys_i = ~clk_sys_i;
    sfs_frontend DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n_i),
        .sck_i(sck_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .start_o(start_o),
        .end_o(end_o), .rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o), .rx_first_o(rx_first_o),
        .tx_byte_i(tx_byte_i), .tx_en_i(tx_en_i), .tx_load_o(tx_load_o),
        .core_busy_i(core_busy_i), .active_o(active_o), .state_o(state_o));
    sfs_host_model host (.sel_n_o(sel_n_i), .sck_o(sck_i), .sdi_o(sdi_i), .sdo_i(sdo_o),
        .sdo_oe_i(sdo_oe_o));
    // count cycles, cut a hang short
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    // record pulses where settled; keep the byte just taken, then offer a fresh one
    always @(negedge clk_sys_i) begin
        if (rx_valid_o === 1'b1) rxq.push_back({rx_first_o, rx_byte_o});
        if (start_o === 1'b1) n_start++;
        if (end_o === 1'b1) n_end++;
        if (tx_load_o === 1'b1) begin
            txq.push_back(tx_byte_i);
            tx_byte_i <= $random(seed);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] exp_rx(input logic [7:0] b, input int k);
        return {k == 0, b};
    endfunction
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one framed sequence: n bytes, optional partial tail, optional busy close
    task automatic run_seq(input bit m3, input bit tx, input int n, input bit busy, input bit part);
        logic [7:0] d[4];
        logic [7:0] r;
        rxq.delete();
        txq.delete();
        n_start = 0;
        n_end = 0;
        host.mode3 = m3;
        @(negedge clk_sys_i) tx_en_i = tx;
        host.open_seq();
        for (int k = 0; k < n; k++) begin
            d[k] = $random(seed);
            host.xfer(d[k], 8, r);
            if (tx) chk("sdo byte", {1'b0, txq[k]}, {1'b0, r});
        end
        if (part) host.xfer(8'hA5, 4, r);
        @(negedge clk_sys_i) core_busy_i = busy;
        host.close_seq();
        if (busy) begin
            chk("busy state", {5'h00, SFS_BUSY}, {5'h00, state_o});
            chk("busy active", 9'h001, {8'h00, active_o});
            @(negedge clk_sys_i) core_busy_i = 1'b0;
            repeat (4) @(negedge clk_sys_i);
        end
        chk("idle state", {5'h00, SFS_IDLE}, {5'h00, state_o});
        chk("rx count", 9'(n), 9'(rxq.size()));
        chk("start count", 9'h001, 9'(n_start));
        chk("end count", 9'h001, 9'(n_end));
        chk("load count", tx ? 9'(n) : 9'h000, 9'(txq.size()));
        for (int k = 0; k < n; k++) chk("rx byte", exp_rx(d[k], k), rxq[k]);
        $display("sequence mode %0d bytes %0d done", m3 ? 3 : 0, n);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // main sequence: corners, mid-run reset, then random mixes
    initial begin
        repeat (12) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        run_seq(1'b0, 1'b0, 3, 1'b0, 1'b1);
        run_seq(1'b1, 1'b1, 3, 1'b0, 1'b0);
        run_seq(1'b0, 1'b0, 1, 1'b1, 1'b0);
        rst_n_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        n_start = 0;
        chk("reset state", {5'h00, SFS_IDLE}, {5'h00, state_o});
        repeat (6) @(negedge clk_sys_i);
        chk("reset start", 9'h000, 9'(n_start));
        chk("reset settled", {5'h00, SFS_IDLE}, {5'h00, state_o});
        for (int i = 0; i < 6; i++) run_seq(i[0], i[0], 1 + i % 3, i % 3 == 2, 1'b0);
        end_sim();
    end
endmodule
